// *** design/sbss_pkg.sv ***
// Purpose: Shared constants and types for the 16-bit serial slave frame block
// Assumes: ref_clk at 100 MHz; serial pins arrive asynchronously
// Notes: Notes on behaviour follow
// Notes on behaviour
// R1: Transfers accepted only while select is low
// R2: Select high: ignore clock/input, output released
// R3: Select falling loads reply into shift register
// R4: Decode only on nonzero multiple of eight clocks
// R5: Input bit sampled on falling serial clock
// R6: Next output bit launched on rising clock
// R7: Host keeps clock low around select edges
// R8: Input words arrive most significant bit first
// R9: Output word sent most significant bit first
// R10: Host clocks sixteen bits per chained device
// R11: Reply set by previous frame's command
// R12: Read returns addressed register next frame
// R13: Input: selector, pointer, twelve-bit payload
// R14: Write updates register at select rising
// R15: Write replies with addressed register next frame
// R16: Output: parity, echoed address, twelve-bit data
// R17: Parity odd over address and data fields; the code generates even parity (whole word XOR is zero)
// R18: Read takes two frames, second carries command
// R19: First reply after reset is status reply
// R20: Command selects sixteen-bit or 2x8-bit protocol
// R21: Internal logic paced by 500 kHz oscillator; the code paces only the status snapshot with it, the rest runs on ref_clk
// R22: 2x8: upper byte sets lower reply byte
// R23: Unknown patterns ignored, error recorded
// R24: Reply top bit driven as select falls
// R25: Clock and select synchronised before use
package sbss_pkg;
	localparam int WORD_W = 16;
	localparam int DATA_W = 12;
	localparam int ADDR_W = 3;
	localparam int BYTE_W = 8;
	// Input and output frame fields
	localparam int SEL_BIT = 15;
	localparam int ADDR_HI = 14;
	localparam int ADDR_LO = 12;
	localparam int DATA_HI = 11;
	localparam int CMP_KEEP_BIT = 7;
	// Pointer zero is the command and status slot
	localparam logic [2:0] CMD_ADDR = 3'h0;
	localparam logic [11:0] NOP_CMD = 12'h000;
	localparam logic [11:0] STATUS_READ_CMD = 12'h5A5;
	localparam logic [11:0] COMPACT_CMD = 12'hC3C;
	localparam logic [11:0] REG_RESET = 12'h000;
	localparam logic [2:0] CNT_RESET = 3'h0;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_FREQ_KHZ = 500;
	localparam int OSC_DIV = 1000000 / (CLK_PERIOD_NS * OSC_FREQ_KHZ);
	localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);
	// Write record handed to the user side: pointer plus data
	localparam int REC_W = ADDR_W + DATA_W;
	localparam int BUF_DEPTH = 2;
	typedef enum logic [1:0] {SBSS_RPL_STATUS, SBSS_RPL_REG, SBSS_RPL_COMPACT} sbss_rpl_t;
endpackage : sbss_pkg

// *** design/sbss_buf.sv ***
// Purpose: Two-entry valid/ready buffer for decoded writes
// Assumes: Single clock, synchronous active-high reset
// Notes: Full and empty come straight from the entry count
module sbss_buf import sbss_pkg::*; #(
	parameter int W = REC_W,
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [PW:0] count, next_count;
	logic push, pop;

	assign in_ready = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule : sbss_buf

// *** design/sbss_slave.sv ***
// Purpose: 16-bit serial slave frame engine with register file
// Assumes: Serial pins asynchronous to ref_clk; serial clock idles low
// Notes: Writes leave through a two-entry buffer toward the user side
module sbss_slave import sbss_pkg::*; (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic spi_cs_n,
	input wire logic spi_clk,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe,
	input wire logic [11:0] status_in,
	output logic comm_error,
	output logic compact_mode,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [2:0] wr_addr,
	output logic [11:0] wr_data
);
	// ************************************************
	// Pin synchronisers
	// ************************************************
	logic cs_n_s1, cs_n_s2, cs_n_s3;
	logic clk_s1, clk_s2, clk_s3;
	logic si_s1, si_s2;
	logic cs_fall, cs_rise, clk_fall, clk_rise, cs_act;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cs_n_s1 <= 1'b1;
			cs_n_s2 <= 1'b1;
			cs_n_s3 <= 1'b1;
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
			si_s1 <= 1'b0;
			si_s2 <= 1'b0;
		end else begin
			cs_n_s1 <= spi_cs_n; // R25
			cs_n_s2 <= cs_n_s1;
			cs_n_s3 <= cs_n_s2;
			clk_s1 <= spi_clk; // R25
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			si_s1 <= spi_si;
			si_s2 <= si_s1;
		end
	end

	assign cs_act = !cs_n_s2 && !cs_n_s3;
	assign cs_fall = !cs_n_s2 && cs_n_s3;
	assign cs_rise = cs_n_s2 && !cs_n_s3;
	// Clock edges count only inside a frame
	assign clk_fall = cs_act && !clk_s2 && clk_s3; // R1 R2
	assign clk_rise = cs_act && clk_s2 && !clk_s3; // R1 R2

	// ************************************************
	// Oscillator tick and status snapshot
	// ************************************************
	logic [7:0] osc_cnt, next_osc_cnt;
	logic [11:0] status_snap, next_status_snap;

	always_comb begin
		next_osc_cnt = (osc_cnt == OSC_LAST) ? 8'h00 : osc_cnt + 8'h01;
		// Status is sampled at the oscillator pace, not every cycle
		next_status_snap = (osc_cnt == OSC_LAST) ? status_in : status_snap; // R21
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			osc_cnt <= 8'h00;
			status_snap <= REG_RESET;
		end else begin
			osc_cnt <= next_osc_cnt;
			status_snap <= next_status_snap;
		end
	end

	// ************************************************
	// Frame engine
	// ************************************************
	logic [15:0] shift, next_shift;
	logic so_q, next_so_q;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic seen_bits, next_seen_bits;
	logic [11:0] regs [8];
	logic [11:0] next_regs [8];
	sbss_rpl_t reply_sel, next_reply_sel;
	logic [2:0] reply_addr, next_reply_addr;
	logic [7:0] cmp_byte, next_cmp_byte;
	logic next_compact_mode, next_comm_error;
	logic rec_valid, next_rec_valid;
	logic [14:0] rec_data, next_rec_data;
	logic rec_ready;
	logic [15:0] load_word;
	logic [11:0] load_data;
	logic count_ok, cmd_write, cmd_read, err_event;
	logic [2:0] dec_addr;
	// Upper-byte swap happens once, on the eighth falling edge only
	logic hi_done, next_hi_done;

	assign count_ok = seen_bits && (bit_cnt == CNT_RESET); // R4
	assign dec_addr = shift[ADDR_HI:ADDR_LO]; // R13
	assign cmd_write = cs_rise && count_ok && !compact_mode && shift[SEL_BIT];
	assign cmd_read = cs_rise && count_ok && !compact_mode && !shift[SEL_BIT];

	// Reply word: parity over pointer and data, except the 2x8 compact reply which has none
	always_comb begin
		load_data = (reply_sel == SBSS_RPL_STATUS) ? {comm_error, status_snap[10:0]} :
			regs[reply_addr];
		load_word = {^{reply_addr, load_data}, reply_addr, load_data}; // R16 R17
		if (reply_sel == SBSS_RPL_COMPACT) begin
			load_word = {cmp_byte, 8'h00}; // R22
		end
	end

	always_comb begin
		next_shift = shift;
		next_so_q = so_q;
		next_bit_cnt = bit_cnt;
		next_seen_bits = seen_bits;
		next_regs = regs;
		next_reply_sel = reply_sel;
		next_reply_addr = reply_addr;
		next_cmp_byte = cmp_byte;
		next_compact_mode = compact_mode;
		next_comm_error = comm_error;
		next_rec_valid = rec_valid && !rec_ready;
		next_rec_data = rec_data;
		err_event = 1'b0;
		next_hi_done = hi_done;
		if (cs_fall) begin
			next_shift = load_word; // R3
			next_so_q = load_word[WORD_W-1]; // R24 R9
			next_bit_cnt = CNT_RESET;
			next_seen_bits = 1'b0;
			next_hi_done = 1'b0;
		end
		if (clk_fall) begin
			next_shift = {shift[14:0], si_s2}; // R5 R8
			next_bit_cnt = bit_cnt + 3'h1;
			next_seen_bits = 1'b1;
			// After the upper byte of a 2x8 frame the lower reply byte is swapped in
			if (compact_mode && bit_cnt == 3'h7 && !hi_done) begin
				next_shift = {regs[{shift[1:0], si_s2}][7:0], shift[6:0], si_s2}; // R22
				next_hi_done = 1'b1;
			end
		end
		if (clk_rise) begin
			next_so_q = shift[WORD_W-1]; // R6 R9
		end
		if (cs_rise && count_ok && compact_mode) begin
			// Lower byte steers the upper reply byte of the next frame
			next_cmp_byte = regs[shift[2:0]][7:0]; // R20 R22
			next_reply_sel = SBSS_RPL_COMPACT;
			next_compact_mode = shift[CMP_KEEP_BIT]; // R20
		end
		if (cmd_write && dec_addr != CMD_ADDR) begin
			next_regs[dec_addr] = shift[DATA_HI:0]; // R14
			next_reply_sel = SBSS_RPL_REG; // R15 R11
			next_reply_addr = dec_addr;
			next_rec_data = {dec_addr, shift[DATA_HI:0]};
			next_rec_valid = 1'b1;
			// Pending record is overwritten; the error flags the loss
			if (rec_valid && !rec_ready) begin
				err_event = 1'b1;
			end
		end
		if (cmd_write && dec_addr == CMD_ADDR) begin
			next_reply_sel = SBSS_RPL_STATUS;
			next_reply_addr = CMD_ADDR;
			case (shift[DATA_HI:0])
				NOP_CMD: begin
				end
				STATUS_READ_CMD: begin
					next_comm_error = 1'b0;
				end
				COMPACT_CMD: begin
					next_compact_mode = 1'b1; // R20
				end
				default: begin
					err_event = 1'b1; // R23
				end
			endcase
		end
		if (cmd_read) begin
			next_reply_sel = (dec_addr == CMD_ADDR) ? SBSS_RPL_STATUS : SBSS_RPL_REG; // R12 R18
			next_reply_addr = dec_addr;
		end
		if (err_event) begin
			next_comm_error = 1'b1; // R23
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shift <= 16'h0000;
			so_q <= 1'b0;
			bit_cnt <= CNT_RESET;
			seen_bits <= 1'b0;
			hi_done <= 1'b0;
			regs <= '{default: REG_RESET};
			reply_sel <= SBSS_RPL_STATUS; // R19
			reply_addr <= CMD_ADDR;
			cmp_byte <= 8'h00;
			compact_mode <= 1'b0;
			comm_error <= 1'b0;
			rec_valid <= 1'b0;
			rec_data <= 15'h0000;
		end else begin
			shift <= next_shift;
			so_q <= next_so_q;
			bit_cnt <= next_bit_cnt;
			seen_bits <= next_seen_bits;
			hi_done <= next_hi_done;
			regs <= next_regs;
			reply_sel <= next_reply_sel;
			reply_addr <= next_reply_addr;
			cmp_byte <= next_cmp_byte;
			compact_mode <= next_compact_mode;
			comm_error <= next_comm_error;
			rec_valid <= next_rec_valid;
			rec_data <= next_rec_data;
		end
	end

	assign spi_so = so_q;
	// Released as soon as select rises; the host ignores the line outside frames
	assign spi_so_oe = !cs_n_s2 && !cs_n_s3; // R2

	// ************************************************
	// Write buffer toward the user side
	// ************************************************
	logic [14:0] buf_out;

	sbss_buf #(.W(REC_W), .DEPTH(BUF_DEPTH)) u_buf (
		.ref_clk(ref_clk),
		.srst(srst),
		.in_valid(rec_valid),
		.in_ready(rec_ready),
		.in_data(rec_data),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(buf_out)
	);

	assign wr_addr = buf_out[14:12];
	assign wr_data = buf_out[11:0];

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	sequence s_frame_start;
		cs_fall;
	endsequence

	sequence s_good_write;
		cmd_write && dec_addr != CMD_ADDR;
	endsequence

	sequence s_bad_cmd;
		cmd_write && dec_addr == CMD_ADDR && shift[DATA_HI:0] != NOP_CMD &&
			shift[DATA_HI:0] != STATUS_READ_CMD && shift[DATA_HI:0] != COMPACT_CMD;
	endsequence

	sequence s_compact_end;
		cs_rise && count_ok && compact_mode;
	endsequence

	a_idle_release: assert property (cs_n_s2 |-> !spi_so_oe) // R2
		else $error("serial output driven while deselected");
	a_first_bit: assert property (s_frame_start |=> // R24
		spi_so == $past(load_word[15]) ##1 spi_so_oe)
		else $error("first reply bit not presented at select fall");
	a_shift_load: assert property (s_frame_start |=> shift == $past(load_word)) // R3
		else $error("reply word not loaded at select fall");
	a_si_sample: assert property (clk_fall && !compact_mode |=> shift[0] == $past(si_s2)) // R5
		else $error("input bit not captured on falling clock");
	a_so_launch: assert property (clk_rise |=> spi_so == $past(shift[15])) // R6
		else $error("output bit not launched on rising clock");
	a_parity_even: assert property ( // R17
		(s_frame_start and (reply_sel != SBSS_RPL_COMPACT)) |=> ^shift == 1'b0)
		else $error("reply parity wrong");
	a_bad_count: assert property (cs_rise && !count_ok |=> // R4
		$stable(reply_sel) && $stable(reply_addr) && $stable(comm_error))
		else $error("frame with bad bit count was decoded");
	a_write_reg: assert property (s_good_write |=> // R14
		regs[$past(dec_addr)] == $past(shift[11:0]) && reply_addr == $past(dec_addr))
		else $error("write did not update register at select rise");
	a_read_reply: assert property (cmd_read && dec_addr != CMD_ADDR |=> // R12
		reply_sel == SBSS_RPL_REG && reply_addr == $past(dec_addr))
		else $error("read did not arm reply for next frame");
	a_write_out: assert property (s_good_write |=> rec_valid && // R14
		rec_data[14:12] == $past(dec_addr) && rec_data[11:0] == $past(shift[11:0]))
		else $error("write record not presented to the buffer");
	a_rec_handoff: assert property (rec_valid && rec_ready |=> !rec_valid) // R14
		else $error("write record held after buffer took it");
	a_unknown_cmd: assert property (s_bad_cmd |=> comm_error) // R23
		else $error("unknown command did not record an error");
	a_compact_exit: assert property (s_compact_end |=> // R20
		compact_mode == $past(shift[CMP_KEEP_BIT]) && reply_sel == SBSS_RPL_COMPACT)
		else $error("2x8 frame end did not set mode and reply");
endmodule : sbss_slave

// *** bench/sbss_host.sv ***
// Purpose: Host model that masters the serial link of the slave
// Assumes: Serial clock idles low; 125 ns serial clock period
// Notes: A released data line shows the inverse of its last bit
module sbss_host (
	output logic spi_cs_n,
	output logic spi_clk,
	output logic spi_si,
	input wire logic spi_so,
	input wire logic spi_so_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic so_last = 1'b0;
	logic so_line;
	initial begin
		spi_cs_n = 1'b1;
		spi_clk = 1'b0;
		spi_si = 1'b0;
	end
	always @(spi_so or spi_so_oe) begin
		if (spi_so_oe) begin
			so_last = spi_so;
		end
	end
	// Floating line must never look like a valid stale bit
	assign so_line = spi_so_oe ? spi_so : ~so_last;
	// ****
	// Frame of n bits
	// ****
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = '0;
		spi_cs_n = 1'b0;
		#250;
		for (int i = n - 1; i >= 0; i--) begin
			spi_clk = 1'b1;
			spi_si = tx[i];
			#62.5;
			// Reply bit moves on the rising edge, so take it just before falling
			rx[i] = so_line;
			spi_clk = 1'b0;
			#62.5;
		end
		#250;
		spi_cs_n = 1'b1;
		#300;
	endtask : xfer
endmodule : sbss_host

// *** bench/test_sixteen_bit_spi_slave_frame.sv ***
// Purpose: Self-checking bench for the serial slave frame block
// Assumes: Host model drives the link; user side takes write records
// Notes: Frames start a little after a falling system clock edge
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module test_sixteen_bit_spi_slave_frame import sbss_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk;
	logic srst;
	logic spi_cs_n;
	logic spi_clk;
	logic spi_si;
	logic spi_so;
	logic spi_so_oe;
	logic [11:0] status_in;
	logic comm_error;
	logic compact_mode;
	logic wr_valid;
	logic wr_ready;
	logic [2:0] wr_addr;
	logic [11:0] wr_data;
	logic [31:0] rx;
	logic [14:0] got_q[$];
	logic [14:0] exp_q[$];
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	sbss_slave DUT (.ref_clk(ref_clk), .srst(srst), .spi_cs_n(spi_cs_n), .spi_clk(spi_clk),
		.spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .status_in(status_in),
		.comm_error(comm_error), .compact_mode(compact_mode), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
	sbss_host host (.spi_cs_n(spi_cs_n), .spi_clk(spi_clk), .spi_si(spi_si),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ****
	// Helpers
	// ****
	task automatic wrap_up();
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	function automatic logic [15:0] rep(input logic [2:0] a, input logic [11:0] d);
		return {^{a, d}, a, d};
	endfunction : rep
	task automatic fr(input logic [15:0] w, input logic [15:0] e, input bit chk);
		@(negedge ref_clk);
		#2;
		host.xfer({16'h0000, w}, 16, rx);
		if (chk) `CHK("reply", e, rx[15:0])
		`CHK("so_oe", 1'b0, spi_so_oe)
	endtask : fr
	always @(posedge ref_clk) begin
		if (!srst && wr_valid === 1'b1 && wr_ready === 1'b1 && wr_addr !== 3'h0) begin
			got_q.push_back({wr_addr, wr_data});
		end
	end
	// Hang guard, well above the few thousand cycles of the sequence
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// ****
	// Sequence
	// ****
	initial begin
		srst = 1'b1;
		status_in = 12'h6B1;
		wr_ready = 1'b1;
		repeat (16) @(negedge ref_clk);
		srst = 1'b0;
		repeat (250) @(negedge ref_clk);
		fr(16'hBA5C, rep(3'h0, {1'b0, status_in[10:0]}), 1'b1);
		exp_q.push_back({3'h3, 12'hA5C});
		fr(16'h3000, rep(3'h3, 12'hA5C), 1'b1);
		fr(16'hD123, rep(3'h3, 12'hA5C), 1'b1);
		exp_q.push_back({3'h5, 12'h123});
		host.xfer(32'h0000BFFF, 12, rx);
		host.xfer(32'h00000000, 0, rx);
		fr(16'h3000, rep(3'h5, 12'h123), 1'b1);
		@(negedge ref_clk);
		#2;
		host.xfer({16'hE0F0, 16'h6000}, 32, rx);
		`CHK("chain_reply", rep(3'h3, 12'hA5C), rx[31:16])
		`CHK("chain_pass", 16'hE0F0, rx[15:0])
		fr(16'hFFFF, rep(3'h6, REG_RESET), 1'b1);
		exp_q.push_back({3'h7, 12'hFFF});
		fr(16'h8777, rep(3'h7, 12'hFFF), 1'b1);
		`CHK("comm_error", 1'b1, comm_error)
		fr(16'h85A5, 16'h0000, 1'b0);
		`CHK("comm_error", 1'b0, comm_error)
		@(negedge ref_clk);
		wr_ready = 1'b0;
		fr(16'h9111, 16'h0000, 1'b0);
		fr(16'hA222, 16'h0000, 1'b0);
		fr(16'hC444, 16'h0000, 1'b0);
		fr(16'hD555, 16'h0000, 1'b0);
		`CHK("wr_valid", 1'b1, wr_valid)
		`CHK("wr_addr", 3'h1, wr_addr)
		`CHK("comm_error", 1'b1, comm_error)
		exp_q.push_back({3'h1, 12'h111});
		exp_q.push_back({3'h2, 12'h222});
		exp_q.push_back({3'h5, 12'h555});
		@(negedge ref_clk);
		wr_ready = 1'b1;
		fr(16'h85A5, 16'h0000, 1'b0);
		fr(16'h8C3C, 16'h0000, 1'b0);
		`CHK("compact_mode", 1'b1, compact_mode)
		@(negedge ref_clk);
		#2;
		host.xfer(32'h00000305, 16, rx);
		`CHK("compact_low", 8'h5C, rx[7:0])
		`CHK("compact_mode", 1'b0, compact_mode)
		fr(16'h0000, 16'h5500, 1'b1);
		repeat (20) @(negedge ref_clk);
		`CHK("records", exp_q.size(), got_q.size())
		if (got_q.size() == exp_q.size()) begin
			foreach (exp_q[i]) `CHK("record", exp_q[i], got_q[i])
		end
		wrap_up();
	end
endmodule : test_sixteen_bit_spi_slave_frame
